// >>> core/counter_if.sv
/*
 * Link between the status block and one error counter.
 * Assumes both ends run on the same reference clock.
 */
`timescale 1ns/100ps
interface counter_if;
    logic        inc;   // count one error this cycle
    logic        latch; // interval boundary: transfer and restart
    logic [15:0] held;  // count of the previous interval

    modport owner   (output inc, output latch, input held);
    modport counter (input inc, input latch, output held);
endinterface : counter_if

// >>> core/e1_status_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the E1 status,
 * mask and error-counter block.
 * Assumes a 25 MHz reference clock and a 2.048 MHz receive line clock.
 */
`ifndef E1_STATUS_PARAMS_SVH
`define E1_STATUS_PARAMS_SVH

// register offsets on the parallel control port
`define OFS_VIOL_HIGH     8'h00
`define OFS_VIOL_LOW      8'h01
`define OFS_CRC_HIGH      8'h02
`define OFS_CRC_LOW       8'h03
`define OFS_ALARM_STATUS  8'h06
`define OFS_EVENT_STATUS  8'h07
`define OFS_ALARM_MASK    8'h16
`define OFS_EVENT_MASK    8'h17

// bit positions in frame_event_status and event_interrupt_mask
`define EV_RX_MF          7
`define EV_RX_ALIGN       6
`define EV_TX_MF          5
`define EV_TIMER          4
`define EV_TX_ALIGN       3
`define EV_TX_CLK_LOSS    2
`define EV_RX_CRC_MF      1
`define EV_TX_SLIP        0
// bit position of the sync-loss alarm in alarm_status
`define AL_SYNC_LOSS      0

// reset values
`define MASK_RESET        8'h00
`define STATUS_RESET      8'h00

// counter index, saturation values and field layout of offset 02
`define CNT_VIOL          0
`define CNT_CRC           1
`define CNT_FAS           2
`define CNT_EBIT          3
`define VIOL_MAX          16'hFFFF
`define CRC_MAX           16'h03FF
`define FAS_MAX           16'h0FFF
`define EBIT_MAX          16'h03FF
`define CRC_HIGH_MSB      9
`define CRC_HIGH_LSB      8
`define FAS_TOP_MSB       11
`define FAS_TOP_LSB       6

// timing: transmit clock loss after one channel time (least time, rounded up)
`define CLK_PERIOD_NS     40
`define TRANSMIT_CLOCK_INPUT_LOSS_NS      3900
`define TRANSMIT_CLOCK_INPUT_LOSS_CYCLES  ((`TRANSMIT_CLOCK_INPUT_LOSS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// timing in receive line clock edges
`define RCLK_HZ           2048000
`define FAST_US           62500
`define ARB_MF_US         2000
`define SEC_EDGES         (`RCLK_HZ)
`define FAST_EDGES        ((`RCLK_HZ / 1000) * `FAST_US / 1000)
`define ARB_MF_EDGES      ((`RCLK_HZ / 1000) * `ARB_MF_US / 1000)

`endif

// >>> core/e1_status_pkg.sv
/*
 * Types of the E1 status block: the state records of the main module and
 * of the error counter.
 * Assumes the widths fixed in e1_status_params.svh.
 */
package e1_status_pkg;

    // state of one saturating error counter
    typedef struct packed {
        logic [15:0] run;       // count of the current interval
        logic [15:0] held;      // count of the previous interval
    } cnt_state_s;

    // whole state of the status and mask block
    typedef struct packed {
        logic        rclk_s1;   // receive clock synchroniser, first stage
        logic        rclk_s2;   // receive clock synchroniser, second stage
        logic        rclk_d;    // delayed copy for edge detection
        logic        transmit_clock_input_s1;   // transmit clock synchroniser, first stage
        logic        transmit_clock_input_s2;   // transmit clock synchroniser, second stage
        logic        transmit_clock_input_d;    // delayed copy for edge detection
        logic [6:0]  transmit_clock_input_idle; // cycles since last transmit clock edge
        logic        transmit_clock_input_lost; // live loss-of-transmit-clock condition
        logic [20:0] ivl_cnt;   // receive clock edges in this interval
        logic [11:0] arb_cnt;   // receive clock edges for free-running crc mf
        logic [7:0]  sr1;       // alarm_status
        logic [7:0]  sr2;       // frame_event_status
        logic [7:0]  alarm_interrupt_mask;      // alarm_interrupt_mask
        logic [7:0]  event_interrupt_mask;      // event_interrupt_mask
        logic        mark_pol;  // polarity of last mark
        logic        mark_seen; // a mark has been seen
        logic        bpv_pol;   // polarity of last bipolar violation
        logic        bpv_seen;  // a bipolar violation has been seen
        logic [7:0]  rd_data;   // read data holding register
    } state_s;

endpackage : e1_status_pkg

// >>> core/e1_status_regs.sv
/*
 * Status flags, interrupt masks and latched error counters of an E1 framer,
 * reached over the parallel control port.
 * Assumes framer events arrive as one-cycle pulses on ref_clk_in; the
 * receive and transmit line clocks arrive from pins and are synchronised.
 *
 */
`timescale 1ns/100ps
`include "e1_status_params.svh"
module e1_status_regs
    import e1_status_pkg::*;
#(
    parameter int SEC_EDGES  = `SEC_EDGES,  // receive clock edges per second
    parameter int FAST_EDGES = `FAST_EDGES  // receive clock edges per fast interval
) (
    input  wire logic        ref_clk_in,         // 25 MHz reference clock
    input  wire logic        reset_in,           // synchronous, active high
    input  wire logic        ce_in,              // clock enable, freezes all state
    // parallel control port
    input  wire logic [7:0]  addr_in,            // register offset
    input  wire logic        wr_en_in,           // write strobe
    input  wire logic [7:0]  wr_data_in,         // write data
    input  wire logic        rd_en_in,           // read strobe
    output logic      [7:0]  rd_data_out,        // read data, one cycle later
    output logic             irq_out,            // interrupt, active high
    // line clock pins
    input  wire logic        rx_line_clk_in,     // receive line clock pin
    input  wire logic        transmit_clock_input_in, // transmit clock pin
    // framer events, one-cycle pulses
    input  wire logic        rx_mf_in,           // receive signaling multiframe start
    input  wire logic        rx_align_in,        // receive align frame start
    input  wire logic        tx_mf_in,           // transmit multiframe start
    input  wire logic        tx_align_in,        // transmit align frame start
    input  wire logic        rx_crc_mf_in,       // receive crc4 multiframe start
    input  wire logic        tx_slip_in,         // transmit elastic store slip
    input  wire logic [7:0]  alarm_in,           // receive alarm levels
    // line code and error events
    input  wire logic        rx_mark_in,         // a mark was received
    input  wire logic        rx_mark_neg_in,     // its polarity is negative
    input  wire logic        rx_hdb3_code_in,    // the mark is a valid hdb3 codeword
    input  wire logic        crc_error_in,       // crc4 word error
    input  wire logic        fas_error_in,       // frame alignment word error
    input  wire logic        ebit_error_in,      // received e-bit at zero
    input  wire logic        crc_sync_loss_in,   // crc4 multiframe sync lost
    // control bits
    input  wire logic        fast_interval_in,   // common_control_two bit 7
    input  wire logic        code_viol_mode_in,  // common_control_two bit 6
    input  wire logic        hdb3_enable_in,     // common_control_one bit 2
    input  wire logic        crc4_enable_in,     // common_control_one bit 0
    input  wire logic        clk_loss_pin_en_in, // transmit_control_two bit 0
    // outputs to the framer and other register blocks
    output logic             tx_clock_loss_out,  // loss of transmit clock pin
    output logic      [11:0] fas_count_out,      // previous interval fas count
    output logic      [9:0]  ebit_count_out      // previous interval e-bit count
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    state_s      st_r;            // registered state
    state_s      st_nxt;          // next state
    counter_if   cif [4] ();      // one link per error counter
    logic [15:0] held [4];        // latched counts, by index
    logic [3:0]  inc;             // error pulses, by index
    logic        rclk_rise;       // receive clock rising edge
    logic        ivl_tick;        // interval boundary
    logic        arb_tick;        // free-running 2ms boundary
    logic        bpv_raw;         // same-polarity mark, codewords included
    logic        bipolar_violation;             // bipolar violation this cycle
    logic        cv;              // code violation this cycle
    logic        frame_loss;      // frame alignment lost
    logic [7:0]  ev_set;          // event flags to set
    logic        rd_sr1;          // read of alarm status
    logic        rd_sr2;          // read of event status
    logic [20:0] ivl_limit;       // last edge count of this interval

    ////////////////////////////////////////////////////////////////////////////
    // error counters

    // four identical counters; only saturation value differs
    localparam logic [15:0] CNT_MAX [4] = '{`VIOL_MAX, `CRC_MAX, `FAS_MAX, `EBIT_MAX};

    for (genvar i = 0; i < 4; i++) begin : g_cnt
        assign cif[i].inc   = inc[i];
        assign cif[i].latch = ivl_tick && ce_in;
        assign held[i]      = cif[i].held;
        error_counter #(
            .MAX (CNT_MAX[i])
        ) u_cnt (
            .ref_clk_in (ref_clk_in),
            .reset_in   (reset_in),
            .ce_in      (ce_in),
            .cnt        (cif[i])
        );
    end

    assign fas_count_out  = held[`CNT_FAS][11:0];
    assign ebit_count_out = held[`CNT_EBIT][9:0];

    ////////////////////////////////////////////////////////////////////////////
    // decode of events

    // edges are taken only from second synchroniser stage onward
    assign rclk_rise  = st_r.rclk_s2 && !st_r.rclk_d;
    assign frame_loss = alarm_in[`AL_SYNC_LOSS];
    // fast interval bit picks the shorter period
    assign ivl_limit  = fast_interval_in ? 21'(FAST_EDGES - 1) : 21'(SEC_EDGES - 1);
    assign ivl_tick   = rclk_rise && (st_r.ivl_cnt >= ivl_limit);
    assign arb_tick   = rclk_rise && (st_r.arb_cnt == 12'(`ARB_MF_EDGES - 1));
    assign rd_sr1     = rd_en_in && (addr_in == `OFS_ALARM_STATUS);
    assign rd_sr2     = rd_en_in && (addr_in == `OFS_EVENT_STATUS);

    // line code checking: violation when two marks share a polarity
    always_comb begin
        bpv_raw = rx_mark_in && st_r.mark_seen && (rx_mark_neg_in == st_r.mark_pol);
        bipolar_violation     = bpv_raw;
        // a codeword substitution is not an error in hdb3 mode
        if (hdb3_enable_in && rx_hdb3_code_in) begin
            bipolar_violation = 1'b0;
        end
        // code violation: bipolar violation matching the previous one;
        // codewords alternate in polarity, so they must stay in the history
        cv = bpv_raw && st_r.bpv_seen && (rx_mark_neg_in == st_r.bpv_pol);
    end

    // error pulses per counter
    always_comb begin
        inc = 4'h0;
        // violations count at all times, regardless of sync
        inc[`CNT_VIOL] = code_viol_mode_in ? cv : bipolar_violation;
        // crc errors stop during frame or crc multiframe sync loss
        inc[`CNT_CRC]  = crc_error_in && !frame_loss && !crc_sync_loss_in;
        inc[`CNT_FAS]  = fas_error_in && !frame_loss;
        inc[`CNT_EBIT] = ebit_error_in && !frame_loss && !crc_sync_loss_in;
    end

    // event flags raised this cycle
    always_comb begin
        ev_set                  = 8'h00;
        ev_set[`EV_RX_MF]       = rx_mf_in;
        ev_set[`EV_RX_ALIGN]    = rx_align_in;
        ev_set[`EV_TX_MF]       = tx_mf_in;
        ev_set[`EV_TIMER]       = ivl_tick;
        ev_set[`EV_TX_ALIGN]    = tx_align_in;
        ev_set[`EV_TX_CLK_LOSS] = st_r.transmit_clock_input_lost;
        // without crc4 a free 2ms boundary keeps the flag going
        ev_set[`EV_RX_CRC_MF]   = crc4_enable_in ? rx_crc_mf_in : arb_tick;
        ev_set[`EV_TX_SLIP]     = tx_slip_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;

        // synchronisers: first stage feeds only the second
        st_nxt.rclk_s1 = rx_line_clk_in;
        st_nxt.rclk_s2 = st_r.rclk_s1;
        st_nxt.rclk_d  = st_r.rclk_s2;
        st_nxt.transmit_clock_input_s1 = transmit_clock_input_in;
        st_nxt.transmit_clock_input_s2 = st_r.transmit_clock_input_s1;
        st_nxt.transmit_clock_input_d  = st_r.transmit_clock_input_s2;

        // transmit clock watchdog: any transition restarts it
        if (st_r.transmit_clock_input_s2 != st_r.transmit_clock_input_d) begin
            st_nxt.transmit_clock_input_idle = 7'h00;
            st_nxt.transmit_clock_input_lost = 1'b0;
        end else if (st_r.transmit_clock_input_idle >= 7'(`TRANSMIT_CLOCK_INPUT_LOSS_CYCLES - 1)) begin
            st_nxt.transmit_clock_input_lost = 1'b1;
        end else begin
            st_nxt.transmit_clock_input_idle = st_r.transmit_clock_input_idle + 7'h01;
        end

        // interval timer, counted in receive clock edges
        if (ivl_tick) begin
            st_nxt.ivl_cnt = 21'h000000;
        end else if (rclk_rise) begin
            st_nxt.ivl_cnt = st_r.ivl_cnt + 21'h000001;
        end

        // free-running 2ms count for the crc multiframe flag
        if (arb_tick) begin
            st_nxt.arb_cnt = 12'h000;
        end else if (rclk_rise) begin
            st_nxt.arb_cnt = st_r.arb_cnt + 12'h001;
        end

        // mark and violation polarity history
        if (rx_mark_in) begin
            st_nxt.mark_pol  = rx_mark_neg_in;
            st_nxt.mark_seen = 1'b1;
        end
        // every violation feeds the history, even one excused as a codeword
        if (bpv_raw) begin
            st_nxt.bpv_pol  = rx_mark_neg_in;
            st_nxt.bpv_seen = 1'b1;
        end

        // status: read clears, but a new event in the same cycle wins
        st_nxt.sr2 = (st_r.sr2 & ~(rd_sr2 ? 8'hFF : 8'h00)) | ev_set;
        // alarms stay set while their condition holds
        st_nxt.sr1 = (st_r.sr1 & ~(rd_sr1 ? 8'hFF : 8'h00)) | alarm_in;

        // mask registers
        if (wr_en_in && addr_in == `OFS_ALARM_MASK) begin
            st_nxt.alarm_interrupt_mask = wr_data_in;
        end
        if (wr_en_in && addr_in == `OFS_EVENT_MASK) begin
            st_nxt.event_interrupt_mask = wr_data_in;
        end

        // read data, registered; unmapped offsets read zero
        if (rd_en_in) begin
            unique case (addr_in)
                `OFS_VIOL_HIGH:    st_nxt.rd_data = held[`CNT_VIOL][15:8];
                `OFS_VIOL_LOW:     st_nxt.rd_data = held[`CNT_VIOL][7:0];
                `OFS_CRC_HIGH:     st_nxt.rd_data = {held[`CNT_FAS][`FAS_TOP_MSB:`FAS_TOP_LSB],
                                                     held[`CNT_CRC][`CRC_HIGH_MSB:`CRC_HIGH_LSB]};
                `OFS_CRC_LOW:      st_nxt.rd_data = held[`CNT_CRC][7:0];
                `OFS_ALARM_STATUS: st_nxt.rd_data = st_r.sr1;
                `OFS_EVENT_STATUS: st_nxt.rd_data = st_r.sr2;
                `OFS_ALARM_MASK:   st_nxt.rd_data = st_r.alarm_interrupt_mask;
                `OFS_EVENT_MASK:   st_nxt.rd_data = st_r.event_interrupt_mask;
                default:           st_nxt.rd_data = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // masks start cleared so nothing interrupts before the host asks
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_r      <= '0;
            st_r.sr1  <= `STATUS_RESET;
            st_r.sr2  <= `STATUS_RESET;
            st_r.alarm_interrupt_mask <= `MASK_RESET;
            st_r.event_interrupt_mask <= `MASK_RESET;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rd_data_out       = st_r.rd_data;
    // level interrupt: drops once no enabled flag remains
    assign irq_out           = |(st_r.sr1 & st_r.alarm_interrupt_mask) | |(st_r.sr2 & st_r.event_interrupt_mask);
    // pin follows the live condition, gated by its enable
    assign tx_clock_loss_out = st_r.transmit_clock_input_lost && clk_loss_pin_en_in;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_event_no_clear(logic ev);
        ce_in && ev && !rd_sr2;
    endsequence

    a_rx_mf_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_event_no_clear(rx_mf_in) |=> st_r.sr2[`EV_RX_MF])
        else $error("receive multiframe flag not set");

    a_rx_align_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && rx_align_in) |=> st_r.sr2[`EV_RX_ALIGN])
        else $error("receive align flag not set");

    a_tx_mf_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_event_no_clear(tx_mf_in) |=> st_r.sr2[`EV_TX_MF])
        else $error("transmit multiframe flag not set");

    a_tx_align_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && tx_align_in) |=> st_r.sr2[`EV_TX_ALIGN])
        else $error("transmit align flag not set");

    a_tx_slip_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && tx_slip_in) |=> st_r.sr2[`EV_TX_SLIP])
        else $error("transmit slip flag not set");

    a_timer_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && ivl_tick) |=> (st_r.sr2[`EV_TIMER] && st_r.ivl_cnt == 21'h000000))
        else $error("timer flag or interval restart missing");

    a_clock_loss_pin: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        tx_clock_loss_out == (st_r.transmit_clock_input_lost && clk_loss_pin_en_in))
        else $error("clock loss pin wrong");

    a_clock_loss_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        st_r.transmit_clock_input_lost |-> (st_r.transmit_clock_input_idle == 7'(`TRANSMIT_CLOCK_INPUT_LOSS_CYCLES - 1)))
        else $error("clock loss without a full idle channel time");

    a_clock_loss_set: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && st_r.transmit_clock_input_s2 == st_r.transmit_clock_input_d &&
         st_r.transmit_clock_input_idle == 7'(`TRANSMIT_CLOCK_INPUT_LOSS_CYCLES - 1)) |=> st_r.transmit_clock_input_lost)
        else $error("clock loss flag not raised");

    a_crc_mf_free: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && !crc4_enable_in && arb_tick) |=> st_r.sr2[`EV_RX_CRC_MF])
        else $error("free crc multiframe flag not set");

    a_viol_read: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && rd_en_in && addr_in == `OFS_VIOL_LOW) |=>
        (rd_data_out == $past(held[`CNT_VIOL][7:0])))
        else $error("violation low byte read wrong");

    a_crc_gated: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (frame_loss || crc_sync_loss_in) |-> !inc[`CNT_CRC])
        else $error("crc count during sync loss");

    a_irq_level: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ((st_r.sr2 & st_r.event_interrupt_mask) == 8'h00 && (st_r.sr1 & st_r.alarm_interrupt_mask) == 8'h00) |-> !irq_out)
        else $error("interrupt without enabled flag");

    a_mask_reset: assert property (@(posedge ref_clk_in)
        $past(reset_in) |-> (st_r.alarm_interrupt_mask == `MASK_RESET && st_r.event_interrupt_mask == `MASK_RESET))
        else $error("mask not cleared by reset");

endmodule : e1_status_regs

// >>> core/error_counter.sv
/*
 * One saturating error counter with a latched copy of the last interval.
 * Assumes inc and latch are one-cycle pulses on ref_clk_in.
 */
`timescale 1ns/100ps
`include "e1_status_params.svh"
module error_counter
    import e1_status_pkg::*;
#(
    parameter logic [15:0] MAX = `VIOL_MAX   // saturation value
) (
    input  wire logic  ref_clk_in,
    input  wire logic  reset_in,
    input  wire logic  ce_in,
    counter_if.counter cnt
);

    cnt_state_s st_r;   // registered state
    cnt_state_s st_nxt; // next state

    assign cnt.held = st_r.held;

    // count, saturate, transfer on boundary
    always_comb begin
        st_nxt = st_r;
        if (cnt.latch) begin
            // an error on the boundary belongs to the new interval
            st_nxt.held = st_r.run;
            st_nxt.run  = cnt.inc ? 16'h0001 : 16'h0000;
        end else if (cnt.inc && st_r.run != MAX) begin
            st_nxt.run = st_r.run + 16'h0001;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    a_count_saturates: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && !cnt.latch && st_r.run == MAX) |=> (st_r.run == MAX))
        else $error("error counter left its maximum");

    a_count_transfer: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (ce_in && cnt.latch) |=> (st_r.held == $past(st_r.run)))
        else $error("interval count not transferred");

endmodule : error_counter

// >>> sim/e1_status_regs_tb.sv
/* self-checking bench of the status, mask and counter block.
   assumes host_model and the core files */
`timescale 1ns/100ps
module e1_status_regs_tb;
    logic clk = 0, rst = 1, rxc = 0, txc = 0, tx_run = 1, mk = 0, err = 0, irq, loss;
    logic we, re, ce = 1;       // host strobes and clock enable
    time t;                     // start of a timed interval
    logic [7:0] addr, wd, rd, v, alarm = 0, ctl = 8'hC0; // ctl: pins and control bits
    logic [5:0] ev = 0;         // framer event pulses
    logic [11:0] fas;
    logic [9:0] eb;
    int fails = 0, samples_checked = 0;
    always #20 clk = ~clk;
    always #240 rxc = ~rxc;     // 16 rising edges is one short interval
    always #120 if (tx_run) txc = ~txc;
    host_model host_u (.ref_clk_in(clk), .rd_data_in(rd), .addr_out(addr),
        .wr_en_out(we), .wr_data_out(wd), .rd_en_out(re));
    e1_status_regs #(.SEC_EDGES(64), .FAST_EDGES(16)) dut_u (.ref_clk_in(clk),
        .reset_in(rst), .ce_in(ce), .addr_in(addr), .wr_en_in(we), .wr_data_in(wd),
        .rd_en_in(re), .rd_data_out(rd), .irq_out(irq), .rx_line_clk_in(rxc),
        .transmit_clock_input_in(txc), .rx_mf_in(ev[5]), .rx_align_in(ev[4]),
        .tx_mf_in(ev[3]), .tx_align_in(ev[2]), .rx_crc_mf_in(ev[1]), .tx_slip_in(ev[0]),
        .alarm_in(alarm), .rx_mark_in(mk), .rx_mark_neg_in(ctl[0]),
        .rx_hdb3_code_in(ctl[1]), .crc_error_in(err), .fas_error_in(err),
        .ebit_error_in(err), .crc_sync_loss_in(ctl[2]), .fast_interval_in(ctl[3]),
        .code_viol_mode_in(ctl[4]), .hdb3_enable_in(ctl[5]), .crc4_enable_in(ctl[6]),
        .clk_loss_pin_en_in(ctl[7]), .tx_clock_loss_out(loss), .fas_count_out(fas),
        .ebit_count_out(eb));
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [11:0] e);
        host_u.rd(a, v);
        chk({4'h0, v}, e);
    endtask : rdc
    // poll until the timer flag is seen, bounded
    task automatic tick();
        v = 8'h00;
        for (int i = 0; i < 400 && v[4] !== 1'b1; i++) host_u.rd(8'h07, v);
    endtask : tick
    // n error pulses, each with a mark of the polarity set by ctl[0]
    task automatic errs(input int n);
        repeat (n) begin
            @(posedge clk) #1 {err, mk} = 2'b11;
            @(posedge clk) #1 {err, mk} = 2'b00;
        end
    endtask : errs
    task automatic test_done();
        if (fails == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #(40 * 70000) fails++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        rdc(8'h16, 0);
        rdc(8'h17, 0);
        rdc(8'h05, 0);
        alarm = 8'h01;
        host_u.wr(8'h16, 8'h01);
        rdc(8'h16, 8'h01);
        chk(irq, 1);
        rdc(8'h06, 8'h01);
        alarm = 0;
        host_u.wr(8'h16, 8'h00);
        rdc(8'h06, 8'h01);
        rdc(8'h06, 0);
        chk(irq, 0);
        @(posedge clk) #1 ev = 6'h3F;
        @(posedge clk) #1 ev = 0;
        host_u.rd(8'h07, v);
        chk(v & 8'hEF, 8'hEB);
        @(posedge clk) #1 {ce, ev} = 7'h01; // frozen: this slip pulse is lost
        @(posedge clk) #1 {ce, ev} = 7'h40;
        host_u.rd(8'h07, v);
        chk(v[0], 0);
        host_u.wr(8'h17, 8'h01);
        @(posedge clk) #1 ev = 6'h01;
        @(posedge clk) #1 ev = 0;
        @(posedge clk) #1 chk(irq, 1);
        host_u.wr(8'h17, 8'h00);
        chk(irq, 0);
        tick();
        tick();
        chk(v[4], 1);
        errs(3);
        tick();
        rdc(8'h03, 3);
        rdc(8'h02, 0);
        rdc(8'h01, 2);
        rdc(8'h00, 0);
        chk(fas, 3);
        chk(eb, 3);
        alarm = 8'h01;
        errs(2);
        alarm = 0;
        tick();
        rdc(8'h03, 0);
        rdc(8'h01, 2);
        ctl = 8'hF7; // hdb3 line with codewords: count code violations
        errs(2);
        ctl[0] = 1'b0;
        errs(3);
        ctl[4] = 1'b0; // bipolar mode: flagged codewords are excused
        errs(2);
        ctl = 8'hC0;
        tick();
        rdc(8'h01, 1);
        rdc(8'h03, 0);
        chk(fas, 7);
        chk(eb, 0);
        ctl[3] = 1'b1;
        tick();
        t = $time;
        tick();
        chk(12'(($time - t) / 400), 19);
        ctl[6] = 1'b0;
        host_u.rd(8'h07, v);
        repeat (4096 * 12 + 40) @(posedge clk);
        host_u.rd(8'h07, v);
        chk(v[1], 1);
        tx_run = 0;
        repeat (120) @(posedge clk);
        #1 chk(loss, 1);
        host_u.rd(8'h07, v);
        chk(v[2], 1);
        test_done();
    end
endmodule : e1_status_regs_tb

// >>> sim/host_model.sv
/* host cpu on the parallel control port.
   assumes the block's 25 MHz ref clock and one-cycle strobes */
`timescale 1ns/100ps
module host_model (
    input  wire logic       ref_clk_in,
    input  wire logic [7:0] rd_data_in,
    output logic      [7:0] addr_out,
    output logic            wr_en_out,
    output logic      [7:0] wr_data_out,
    output logic            rd_en_out
);
    // bus idle from time zero
    initial begin
        addr_out = 8'h00;
        wr_en_out = 1'b0;
        wr_data_out = 8'h00;
        rd_en_out = 1'b0;
    end
    // one write strobe; data inverted after release so stale values show
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in) #1;
        {addr_out, wr_data_out, wr_en_out} = {a, d, 1'b1};
        @(posedge ref_clk_in) #1;
        {wr_data_out, wr_en_out} = {~d, 1'b0};
    endtask : wr
    // one read strobe; data is taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in) #1;
        {addr_out, rd_en_out} = {a, 1'b1};
        @(posedge ref_clk_in) #1;
        rd_en_out = 1'b0;
        d = rd_data_in;
    endtask : rd
endmodule : host_model
